// ### design/mpss_pkg.sv
`default_nettype none
package mpss_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned MPSS_CLK_HZ = 10_000_000;
  localparam int unsigned MPSS_INIT_S = 50;
  localparam longint unsigned MPSS_INIT_CYCLES =
    longint'(MPSS_INIT_S) * longint'(MPSS_CLK_HZ);
  localparam int unsigned MPSS_FINAL_CYCLES = 16;
  localparam int unsigned MPSS_WAKE_PERIOD = 64;
  localparam int unsigned MPSS_WAKE_ON = 8;
  localparam int unsigned MPSS_DEEP_PERIOD = 1024;

  // ==========================================================
  // Reset values
  localparam logic MPSS_IND_EN_RST = 1'b0;
  localparam logic MPSS_QUICK_EN_RST = 1'b0;

  // ==========================================================
  // States
  typedef enum logic [2:0] {
    MPSS_OFF = 3'b000,
    MPSS_INIT = 3'b001,
    MPSS_ON = 3'b010,
    MPSS_SLEEP = 3'b011,
    MPSS_DEEP = 3'b100,
    MPSS_FINAL = 3'b101,
    MPSS_DONE = 3'b110
  } mpss_state_t;

endpackage
`default_nettype wire

// ### design/mpss_sync.sv
`timescale 1ns/100ps
`default_nettype none
module mpss_sync
  import mpss_pkg::*;
#(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Levels
  input wire logic [WIDTH-1:0] async_i,
  input wire logic [WIDTH-1:0] reset_value_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;

  // Reset value held as a constant per instance by the caller
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      meta <= reset_value_i;
      sync_o <= reset_value_i;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule // mpss_sync
`default_nettype wire

// ### design/mpss_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module mpss_sequencer
  import mpss_pkg::*;
#(
  parameter longint unsigned INIT_CYCLES = MPSS_INIT_CYCLES,
  parameter int unsigned FINAL_CYCLES = MPSS_FINAL_CYCLES
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Host power lines
  input wire logic power_off_n_i,
  input wire logic main_supply_rail_i,
  // Optional function assignment commands
  input wire logic indicator_assign_command_i,
  input wire logic indicator_assign_value_i,
  input wire logic quick_off_assign_command_i,
  input wire logic quick_off_assign_value_i,
  // Power saving requests
  input wire logic sleep_req_i,
  input wire logic deep_power_saving_req_i,
  input wire logic wake_req_i,
  // Fast shutdown trigger pin
  input wire logic quick_off_trigger_i,
  // Status
  output logic baseband_power_o,
  output logic operational_o,
  output logic [2:0] state_o,
  // Boot and shutdown indicator pin
  output logic indicator_o,
  output logic indicator_oe_n_o
);

  // ==========================================================
  // Input synchronisation
  logic [1:0] sync_q;
  logic pwr_s;
  logic trig_s;
  logic trig_prev;
  logic trig_fall;

  mpss_sync #(.WIDTH(2)) u_sync (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .async_i({quick_off_trigger_i, power_off_n_i}),
    .reset_value_i(2'b00),
    .sync_o(sync_q)
  );
  // Bit 0 is the power-off line, bit 1 the trigger
  assign pwr_s = sync_q[0];
  assign trig_s = sync_q[1];

  // Resets low like the synchroniser output, so no false edge after reset
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      trig_prev <= 1'b0;
    end else begin
      trig_prev <= trig_s;
    end
  end
  assign trig_fall = trig_prev && !trig_s;

  // ==========================================================
  // Function enables
  logic ind_en;
  logic quick_en;

  // Enables survive shutdown; only reset or a command changes them
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      ind_en <= MPSS_IND_EN_RST;
    end else if (indicator_assign_command_i) begin
      ind_en <= indicator_assign_value_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      quick_en <= MPSS_QUICK_EN_RST;
    end else if (quick_off_assign_command_i) begin
      quick_en <= quick_off_assign_value_i;
    end
  end

  // ==========================================================
  // Decoding
  // Baseband is cycled, not held, in both saving states
  function automatic logic mpss_is_saving(input mpss_state_t s);
    return (s == MPSS_SLEEP) || (s == MPSS_DEEP);
  endfunction

  // ==========================================================
  // State machine
  mpss_state_t state;
  mpss_state_t next_state;
  logic [63:0] count;
  logic [63:0] next_count;
  logic [10:0] duty;
  logic shut_req;

  // Graceful or armed fast shutdown request
  assign shut_req = !pwr_s || (quick_en && trig_fall);

  always_comb begin
    next_state = state;
    next_count = count + 64'h1;
    case (state)
      MPSS_OFF: begin
        next_count = 64'h0;
        if (pwr_s && main_supply_rail_i) begin
          next_state = MPSS_INIT;
        end
      end
      MPSS_INIT: begin
        if (shut_req) begin
          next_state = MPSS_FINAL;
          next_count = 64'h0;
        end else if (count >= INIT_CYCLES - 64'h1) begin
          next_state = MPSS_ON;
        end
      end
      MPSS_ON, MPSS_SLEEP, MPSS_DEEP: begin
        next_count = 64'h0;
        if (shut_req) begin
          next_state = MPSS_FINAL;
        end else if (state == MPSS_ON && deep_power_saving_req_i) begin
          next_state = MPSS_DEEP;
        end else if (state == MPSS_ON && sleep_req_i) begin
          next_state = MPSS_SLEEP;
        end else if (mpss_is_saving(state) && wake_req_i) begin
          next_state = MPSS_ON;
        end
      end
      MPSS_FINAL: begin
        if (count >= 64'(FINAL_CYCLES) - 64'h1) begin
          next_state = MPSS_DONE;
          next_count = 64'h0;
        end
      end
      MPSS_DONE: begin
        next_count = 64'h0;
        // Supply still up with power-off high: boot again
        if (pwr_s && main_supply_rail_i) begin
          next_state = MPSS_INIT;
        end else if (!main_supply_rail_i || !pwr_s) begin
          next_state = MPSS_OFF;
        end
      end
      default: begin
        next_state = MPSS_OFF;
        next_count = 64'h0;
      end
    endcase
    // Supply loss wins over every state and request
    if (!main_supply_rail_i) begin
      next_state = MPSS_OFF;
      next_count = 64'h0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state <= MPSS_OFF;
      count <= 64'h0;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  // Duty counter for the low power states, wraps within them and is cleared outside them
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      duty <= 11'h000;
    end else if (mpss_is_saving(next_state)) begin
      duty <= duty + 11'h001;
    end else begin
      duty <= 11'h000;
    end
  end

  // ==========================================================
  // Outputs
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      baseband_power_o <= 1'b0;
      operational_o <= 1'b0;
      state_o <= 3'h0;
    end else begin
      case (next_state)
        // Saving states: on for the first counts of each period
        MPSS_OFF, MPSS_DONE: baseband_power_o <= 1'b0;
        MPSS_SLEEP:
          baseband_power_o <=
            (duty[5:0] < 6'(MPSS_WAKE_ON));
        MPSS_DEEP:
          baseband_power_o <=
            (duty[9:0] < 10'(MPSS_WAKE_ON));
        default: baseband_power_o <= 1'b1;
      endcase
      operational_o <= (next_state == MPSS_ON);
      state_o <= next_state;
    end
  end

  // Indicator: high after boot, low after shutdown
  // Value kept while disabled; only the enable is gated
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      indicator_o <= 1'b0;
      indicator_oe_n_o <= 1'b1;
    end else begin
      indicator_oe_n_o <= !ind_en;
      if (next_state == MPSS_ON) begin
        indicator_o <= 1'b1;
      end else if (next_state == MPSS_DONE) begin
        indicator_o <= 1'b0;
      end
    end
  end

endmodule // mpss_sequencer
`default_nettype wire

// ### tb/mpss_sequencer_checker.sv
`timescale 1ns/100ps
`default_nettype none
module mpss_sequencer_checker
  import mpss_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic power_off_n_i,
  input wire logic main_supply_rail_i,
  input wire logic baseband_power_o,
  input wire logic operational_o,
  input wire logic [2:0] state_o,
  input wire logic indicator_o
);
  // ====================================
  // Sequencer properties
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  a_off_exit_init: assert property (
    $past(state_o) == MPSS_OFF && state_o != MPSS_OFF |->
    state_o == MPSS_INIT) else $error("off left to a wrong state");
  a_init_not_ready: assert property (
    $rose(state_o == MPSS_INIT) |-> (!operational_o) [*8])
    else $error("ready too early");
  a_ready_only_on: assert property (
    operational_o == (state_o == MPSS_ON)) else $error("ready mismatch");
  a_boot_ind_high: assert property (
    state_o == MPSS_ON |-> indicator_o) else $error("indicator low in on");
  a_done_ind_low: assert property (
    state_o == MPSS_DONE |-> !indicator_o && !baseband_power_o)
    else $error("indicator or power high when done");
  a_shutdown_entry: assert property (
    $fell(power_off_n_i) && state_o == MPSS_ON && main_supply_rail_i
    |-> ##[1:5] state_o == MPSS_FINAL) else $error("no finalization");
  a_final_ends: assert property (
    $rose(state_o == MPSS_FINAL) && main_supply_rail_i |->
    ##[1:20] state_o == MPSS_DONE) else $error("finalization hangs");
  a_done_restart: assert property (
    state_o == MPSS_DONE |=> state_o == MPSS_INIT || state_o == MPSS_OFF)
    else $error("bad state after done");
  c_on: cover property (state_o == MPSS_ON);
  c_done: cover property (state_o == MPSS_DONE);
  c_deep: cover property (state_o == MPSS_DEEP);
  c_sleep: cover property (state_o == MPSS_SLEEP);
endmodule // mpss_sequencer_checker
bind mpss_sequencer mpss_sequencer_checker u_chk (.clock_i, .reset_n_i,
  .power_off_n_i, .main_supply_rail_i, .baseband_power_o, .operational_o,
  .state_o, .indicator_o);
`default_nettype wire

// ### tb/mpss_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module mpss_host_model (
  input wire logic clock_i,
  output logic power_off_n_o,
  output logic trigger_o
);
  // ====================================
  // Host power control
  // No restart line: never held low, so no forced restart
  initial begin
    power_off_n_o = 1'b0;
    trigger_o = 1'b0;
  end
  task automatic set_power(input logic on);
    @(posedge clock_i);
    power_off_n_o <= on;
    trigger_o <= on;
  endtask
  task automatic fire();
    @(posedge clock_i);
    trigger_o <= 1'b0;
    repeat (4) @(posedge clock_i);
    trigger_o <= 1'b1;
  endtask
endmodule // mpss_host_model
`default_nettype wire

// ### tb/module_power_state_sequencer_test.sv
`timescale 1ns/100ps
`default_nettype none
module module_power_state_sequencer_test
  import mpss_pkg::*;
;
  // ====================================
  // Bench
  localparam longint unsigned INIT_N = 20;
  localparam int unsigned FINAL_N = 4;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic supply = 1'b1;
  logic ind_cmd = 1'b0;
  logic q_cmd = 1'b0;
  logic q_val = 1'b0;
  logic ind_val = 1'b1;
  logic [2:0] req = 3'h0;
  wire logic pwr_n;
  wire logic trig;
  wire logic bb;
  wire logic op;
  wire logic ind;
  wire logic ind_oe_n;
  wire logic [2:0] state;
  int errors = 0;
  int check_count = 0;
  int n;
  always #50 clock_i = ~clock_i;
  mpss_host_model host (.clock_i, .power_off_n_o(pwr_n), .trigger_o(trig));
  mpss_sequencer #(.INIT_CYCLES(INIT_N), .FINAL_CYCLES(FINAL_N)) dut (
    .clock_i, .reset_n_i, .power_off_n_i(pwr_n), .main_supply_rail_i(supply),
    .indicator_assign_command_i(ind_cmd), .indicator_assign_value_i(ind_val),
    .quick_off_assign_command_i(q_cmd), .quick_off_assign_value_i(q_val),
    .sleep_req_i(req[0]), .deep_power_saving_req_i(req[1]),
    .wake_req_i(req[2]), .quick_off_trigger_i(trig),
    .baseband_power_o(bb), .operational_o(op), .state_o(state),
    .indicator_o(ind), .indicator_oe_n_o(ind_oe_n));
  task automatic check(input string what, input logic [2:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wait_for(input logic [2:0] s, input int lim);
    n = 0;
    while (state !== s && n < lim) begin
      @(negedge clock_i);
      n++;
    end
    check("state", state, s);
  endtask
  task automatic assign_fn(input logic ind_on, input logic quick);
    @(posedge clock_i);
    ind_val <= ind_on;
    ind_cmd <= 1'b1;
    q_cmd <= 1'b1;
    q_val <= quick;
    @(posedge clock_i);
    ind_cmd <= 1'b0;
    q_cmd <= 1'b0;
  endtask
  task automatic t_boot(input logic ind_on);
    assign_fn(ind_on, 1'b0);
    host.set_power(1'b1);
    wait_for(MPSS_INIT, 6);
    check("ready", op, 1'b0);
    check("baseband", bb, 1'b1);
    // Bench stays quiet until the block reports ready
    wait_for(MPSS_ON, 40);
    check("init long", 3'(n >= INIT_N), 3'h1);
    check("ready", op, 1'b1);
    check("indicator", ind, 1'b1);
    check("indicator oe", ind_oe_n, !ind_on);
  endtask
  task automatic t_sleep(input logic [2:0] r, input logic [2:0] s);
    @(posedge clock_i);
    req <= r;
    wait_for(s, 6);
    check("baseband", bb, 1'b1);
    repeat (8) @(negedge clock_i);
    check("baseband", bb, 1'b0);
    @(posedge clock_i);
    req <= 3'h4;
    wait_for(MPSS_ON, 6);
    @(posedge clock_i);
    req <= 3'h0;
  endtask
  task automatic t_graceful();
    host.set_power(1'b0);
    wait_for(MPSS_FINAL, 6);
    check("ready", op, 1'b0);
    wait_for(MPSS_DONE, 10);
    check("final length", 3'(n == FINAL_N), 3'h1);
    check("indicator", ind, 1'b0);
    wait_for(MPSS_OFF, 3);
    check("baseband", bb, 1'b0);
  endtask
  task automatic t_fast();
    t_boot(1'b0);
    host.fire();
    repeat (10) @(negedge clock_i);
    check("state", state, MPSS_ON);
    assign_fn(1'b1, 1'b1);
    host.fire();
    wait_for(MPSS_FINAL, 8);
    wait_for(MPSS_DONE, 10);
    check("indicator", ind, 1'b0);
    check("indicator oe", ind_oe_n, 1'b0);
    wait_for(MPSS_INIT, 3);
    @(posedge clock_i);
    supply <= 1'b0;
    wait_for(MPSS_OFF, 3);
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(negedge clock_i);
    check("state", state, MPSS_OFF);
    check("indicator oe", ind_oe_n, 1'b1);
    check("baseband", bb, 1'b0);
    t_boot(1'b1);
    t_sleep(3'h1, MPSS_SLEEP);
    t_sleep(3'h2, MPSS_DEEP);
    t_graceful();
    t_fast();
    summarize();
  end
  // Whole run is about 120 cycles
  initial begin
    #300000;
    errors++;
    summarize();
  end
endmodule // module_power_state_sequencer_test
`default_nettype wire
